/* File: verilog/lfdc_counters.sv */
/*
  Link frame debug counters: per-link discard and valid-frame counters with
  read-to-latch-and-clear, plus the last corrected and uncorrectable memory
  block addresses, all read over an AXI4-Lite slave.
  Assumes event inputs are single-cycle pulses synchronous to aclk.
*/
`timescale 1ns/100ps
module lfdc_counters
  import lfdc_pkg::*;
(
  input wire logic aclk,                             // 40 MHz system clock
  input wire logic aresetn,                          // Synchronous reset, low
  input wire logic aclken,                           // Freezes all state when low
  input wire lfdc_link_evt_t link_evt [LINKS],       // Frame outcome per link
  input wire lfdc_nvm_evt_t single_correct_evt,      // Corrected fault and block
  input wire lfdc_nvm_evt_t double_detect_evt,       // Uncorrectable fault and block
  input wire logic [ADDR_W-1:0] s_axi_awaddr,        // Write address
  input wire logic [2:0] s_axi_awprot,               // Write protection
  input wire logic s_axi_awvalid,                    // Write address valid
  output logic s_axi_awready,                        // Write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata,         // Write data
  input wire logic [3:0] s_axi_wstrb,                // Write strobes
  input wire logic s_axi_wvalid,                     // Write data valid
  output logic s_axi_wready,                         // Write data ready
  output logic [1:0] s_axi_bresp,                    // Write answer code
  output logic s_axi_bvalid,                         // Write answer valid
  input wire logic s_axi_bready,                     // Write answer ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,        // Read address
  input wire logic [2:0] s_axi_arprot,               // Read protection
  input wire logic s_axi_arvalid,                    // Read address valid
  output logic s_axi_arready,                        // Read address ready
  output logic [DATA_W-1:0] s_axi_rdata,             // Read data
  output logic [1:0] s_axi_rresp,                    // Read answer code
  output logic s_axi_rvalid,                         // Read answer valid
  input wire logic s_axi_rready                      // Read answer ready
);

  lfdc_link_cnt_t cnt_reg [LINKS];
  lfdc_link_cnt_t cnt_next [LINKS];
  lfdc_link_cnt_t snap_reg [LINKS];
  lfdc_link_cnt_t snap_next [LINKS];
  logic [7:0] sec_blk_reg;
  logic [7:0] ded_blk_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [10:0] aw_idx_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  lfdc_rd_state_t rd_state_reg;
  lfdc_rd_state_t rd_state_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Write side: addresses and data taken in either order, then dropped
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_reg || aw_take;
  wire w_have = w_got_reg || w_take;
  wire wr_done = aw_have && w_have;
  wire [10:0] aw_idx_now = s_axi_awaddr[ADDR_W-1:2];
  wire [10:0] wr_idx = aw_got_reg ? aw_idx_reg : aw_idx_now;
  wire b_take = aclken && bvalid_reg && s_axi_bready;

  assign s_axi_awready = aclken && !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = aclken && !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Read side
  wire [10:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_take = aclken && s_axi_rvalid && s_axi_rready;
  wire [LINKS-1:0] rd_clr = ar_take ? lfdc_disc_hit(rd_idx) : '0;
  wire rd_mapped = lfdc_mapped(rd_idx);

  assign s_axi_arready = aclken && (rd_state_reg == RD_IDLE);
  assign s_axi_rvalid = (rd_state_reg == RD_RESP);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  logic [7:0] rd_byte;
  always_comb begin
    case (rd_idx)
      IDX_UART_DISC: rd_byte = cnt_reg[LINK_UART].disc;
      IDX_UPPER_DISC: rd_byte = cnt_reg[LINK_UPPER].disc;
      IDX_LOWER_DISC: rd_byte = cnt_reg[LINK_LOWER].disc;
      IDX_UART_VHI: rd_byte = snap_reg[LINK_UART].valid[15:8];
      IDX_UART_VLO: rd_byte = snap_reg[LINK_UART].valid[7:0];
      IDX_UPPER_VHI: rd_byte = snap_reg[LINK_UPPER].valid[15:8];
      IDX_UPPER_VLO: rd_byte = snap_reg[LINK_UPPER].valid[7:0];
      IDX_LOWER_VHI: rd_byte = snap_reg[LINK_LOWER].valid[15:8];
      IDX_LOWER_VLO: rd_byte = snap_reg[LINK_LOWER].valid[7:0];
      IDX_SEC_BLK: rd_byte = sec_blk_reg;
      IDX_DED_BLK: rd_byte = ded_blk_reg;
      default: rd_byte = DISC_RST;
    endcase
  end

  // Counter update; an event in the clearing cycle is kept
  always_comb begin
    for (int i = 0; i < LINKS; i++) begin
      cnt_next[i] = cnt_reg[i];
      snap_next[i] = snap_reg[i];
      if (rd_clr[i]) begin
        snap_next[i] = cnt_reg[i];
        cnt_next[i].disc = DISC_RST;
        cnt_next[i].valid = VALID_RST;
      end
      if (link_evt[i].discard) begin
        cnt_next[i].disc = cnt_next[i].disc + DISC_ONE;
      end
      if (link_evt[i].valid && cnt_next[i].valid != VALID_MAX) begin
        cnt_next[i].valid = cnt_next[i].valid + VALID_ONE;
      end
    end
  end

  always_comb begin
    case (rd_state_reg)
      RD_IDLE: rd_state_next = ar_take ? RD_RESP : RD_IDLE;
      RD_RESP: rd_state_next = r_take ? RD_IDLE : RD_RESP;
      default: rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LINKS; i++) begin
        cnt_reg[i] <= '0;
        snap_reg[i] <= '0;
      end
    end else if (aclken) begin
      cnt_reg <= cnt_next;
      snap_reg <= snap_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_blk_reg <= BLK_RST;
    end else if (aclken && single_correct_evt.hit) begin
      sec_blk_reg <= single_correct_evt.block;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ded_blk_reg <= BLK_RST;
    end else if (aclken && double_detect_evt.hit) begin
      ded_blk_reg <= double_detect_evt.block;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (aclken) begin
      if (aw_take) begin
        aw_idx_reg <= aw_idx_now;
      end
      if (wr_done) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= lfdc_mapped(wr_idx) ? RESP_OKAY : RESP_DECERR;
      end else begin
        aw_got_reg <= aw_have;
        w_got_reg <= w_have;
        if (b_take) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      rdata_reg <= RDATA_RST;
      rresp_reg <= RESP_OKAY;
    end else if (aclken) begin
      rd_state_reg <= rd_state_next;
      if (ar_take) begin
        rdata_reg <= {24'h00_0000, rd_byte};
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  AST_UART_DISC_INC: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aclken && link_evt[LINK_UART].discard && !rd_clr[LINK_UART]
    |=> cnt_reg[LINK_UART].disc == $past(cnt_reg[LINK_UART].disc) + DISC_ONE)
    else $error("UART discard count did not step");

  AST_LOWER_DISC_INC: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aclken && link_evt[LINK_LOWER].discard && !rd_clr[LINK_LOWER]
    |=> cnt_reg[LINK_LOWER].disc == $past(cnt_reg[LINK_LOWER].disc) + DISC_ONE)
    else $error("Lower port discard count did not step");

  AST_DISC_READ_LATCH: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_clr[LINK_UART]
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(cnt_reg[LINK_UART].disc)
        && snap_reg[LINK_UART] == $past(cnt_reg[LINK_UART])
        && cnt_reg[LINK_UART].disc <= DISC_ONE)
    else $error("UART discard read did not latch and clear");

  AST_VALID_BYTES: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_take && rd_idx == IDX_UART_VHI
    |=> s_axi_rdata[7:0] == snap_reg[LINK_UART].valid[15:8]
        && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("UART valid high byte read wrong");

  AST_VALID_SAT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aclken && cnt_reg[LINK_UART].valid == VALID_MAX && !rd_clr[LINK_UART]
    |=> cnt_reg[LINK_UART].valid == VALID_MAX)
    else $error("Valid counter wrapped past all ones");

  AST_UPPER_CLEAR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_clr[LINK_UPPER]
    |=> cnt_reg[LINK_UPPER].valid <= VALID_ONE
        && snap_reg[LINK_UPPER].valid == $past(cnt_reg[LINK_UPPER].valid))
    else $error("Upper port valid count not latched and cleared");

  AST_SEC_BLOCK: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aclken && single_correct_evt.hit |=> sec_blk_reg == $past(single_correct_evt.block))
    else $error("Corrected block address not recorded");

  AST_DED_BLOCK: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aclken && double_detect_evt.hit |=> ded_blk_reg == $past(double_detect_evt.block))
    else $error("Uncorrectable block address not recorded");

  AST_WRITE_NO_EFFECT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aclken && wr_done && !link_evt[LINK_UART].discard && !rd_clr[LINK_UART]
    |=> s_axi_bvalid && $stable(cnt_reg[LINK_UART].disc))
    else $error("Write altered a counter or went unanswered");

  AST_RDATA_HOLD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read answer dropped before taken");

  // Freeze, bus answer, counter and block address checks
  AST_FREEZE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !aclken |=> $stable(cnt_reg[LINK_UART]) && $stable(snap_reg[LINK_UART]))
    else $error("Counters moved while clock enable was low");

  AST_WRITE_REFUSED: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write accepted while an answer was pending");

  AST_BRESP_CODE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aclken && wr_done && !lfdc_mapped(wr_idx) |=> s_axi_bresp == RESP_DECERR)
    else $error("Unmapped write not refused");

  AST_READ_ANSWER: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("Read answer late or second read accepted");

  AST_UNMAPPED_READ: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_take && !rd_mapped |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == RDATA_RST)
    else $error("Unmapped read not refused");

  AST_RVALID_DROP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    r_take |=> !s_axi_rvalid)
    else $error("Read answer repeated after it was taken");

  AST_UART_VALID_INC: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aclken && link_evt[LINK_UART].valid && !rd_clr[LINK_UART]
        && cnt_reg[LINK_UART].valid != VALID_MAX
    |=> cnt_reg[LINK_UART].valid == $past(cnt_reg[LINK_UART].valid) + VALID_ONE)
    else $error("UART valid count did not step");

  AST_LOWER_LATCH: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_clr[LINK_LOWER]
    |=> snap_reg[LINK_LOWER] == $past(cnt_reg[LINK_LOWER])
        && cnt_reg[LINK_LOWER].valid <= VALID_ONE)
    else $error("Lower port counts not latched and cleared");

  AST_SEC_HOLD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(aclken && single_correct_evt.hit) |=> $stable(sec_blk_reg))
    else $error("Corrected block address changed without a fault");

  AST_DED_HOLD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(aclken && double_detect_evt.hit) |=> $stable(ded_blk_reg))
    else $error("Uncorrectable block address changed without a fault");

  COV_SATURATE: cover property (
    @(posedge aclk) disable iff (!aresetn)
    cnt_reg[LINK_UART].valid == VALID_MAX && link_evt[LINK_UART].valid);

  COV_CLEAR_WITH_EVENT: cover property (
    @(posedge aclk) disable iff (!aresetn)
    rd_clr[LINK_LOWER] && link_evt[LINK_LOWER].discard);

  COV_WRITE_DONE: cover property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);

  COV_UNMAPPED_READ: cover property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == RESP_DECERR);

endmodule : lfdc_counters

/* File: verilog/lfdc_pkg.sv */
/*
  Package for the link frame debug counters: register indices, reset values,
  answer codes, carrier structs and the read state type.
  Assumes one clock domain; a register's byte address is four times its index.
*/
package lfdc_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;
  localparam int LINKS = 3;

  // Link slots
  localparam int LINK_UART = 0;
  localparam int LINK_UPPER = 1;
  localparam int LINK_LOWER = 2;

  // Register indices; byte address is index times four
  localparam logic [10:0] IDX_UART_DISC = 11'h789;
  localparam logic [10:0] IDX_UPPER_DISC = 11'h78a;
  localparam logic [10:0] IDX_LOWER_DISC = 11'h78b;
  localparam logic [10:0] IDX_UART_VHI = 11'h78c;
  localparam logic [10:0] IDX_UART_VLO = 11'h78d;
  localparam logic [10:0] IDX_UPPER_VHI = 11'h78e;
  localparam logic [10:0] IDX_UPPER_VLO = 11'h78f;
  localparam logic [10:0] IDX_LOWER_VHI = 11'h790;
  localparam logic [10:0] IDX_LOWER_VLO = 11'h791;
  localparam logic [10:0] IDX_SEC_BLK = 11'h7a0;
  localparam logic [10:0] IDX_DED_BLK = 11'h7a1;

  // Field positions inside the 32-bit data word
  localparam int BYTE_LSB = 0;
  localparam int BYTE_MSB = 7;

  // Reset and limit values
  localparam logic [7:0] DISC_RST = 8'h00;
  localparam logic [7:0] DISC_ONE = 8'h01;
  localparam logic [15:0] VALID_RST = 16'h0000;
  localparam logic [15:0] VALID_ONE = 16'h0001;
  localparam logic [15:0] VALID_MAX = 16'hffff;
  localparam logic [7:0] BLK_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // AXI answer codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic discard;  // One frame discarded this cycle
    logic valid;    // One valid frame this cycle
  } lfdc_link_evt_t;

  typedef struct packed {
    logic [7:0] disc;
    logic [15:0] valid;
  } lfdc_link_cnt_t;

  typedef struct packed {
    logic hit;          // Fault seen this cycle
    logic [7:0] block;  // Block address of that fault
  } lfdc_nvm_evt_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } lfdc_rd_state_t;

  // One-hot link select for a discard register index
  function automatic logic [LINKS-1:0] lfdc_disc_hit(input logic [10:0] idx);
    lfdc_disc_hit = {idx == IDX_LOWER_DISC, idx == IDX_UPPER_DISC, idx == IDX_UART_DISC};
  endfunction : lfdc_disc_hit

  // Any register of the bank
  function automatic logic lfdc_mapped(input logic [10:0] idx);
    lfdc_mapped = (idx >= IDX_UART_DISC && idx <= IDX_LOWER_VLO) ||
                  idx == IDX_SEC_BLK || idx == IDX_DED_BLK;
  endfunction : lfdc_mapped

endpackage : lfdc_pkg

/* File: tb/lfdc_frame_src.sv */
/*
  Frame and memory fault source standing in for the links and the memory
  checker beside the counter bank. Assumes it runs on the bank clock.
*/
`timescale 1ns/100ps
module lfdc_frame_src
  import lfdc_pkg::*;
(
  input wire logic aclk,                    // Bank clock
  output lfdc_link_evt_t link_evt [LINKS],  // Frame outcome pulses
  output lfdc_nvm_evt_t sec_evt,            // Corrected fault
  output lfdc_nvm_evt_t ded_evt             // Uncorrectable fault
);
  initial begin
    foreach (link_evt[i]) link_evt[i] = '0;
    sec_evt = '{hit: 1'b0, block: 8'h5a};
    ded_evt = '{hit: 1'b0, block: 8'ha5};
  end

  // Static task: its arguments may steer a non-blocking assignment
  task burst(input int l, input logic d, input logic v, input int n);
    repeat (n) begin
      @(posedge aclk);
      link_evt[l] <= '{discard: d, valid: v};
    end
    @(posedge aclk);
    link_evt[l] <= '0;
  endtask : burst

  // Block lines flip once the hit is gone, so a stray capture shows
  task fault(input logic dd, input logic [7:0] blk);
    @(posedge aclk);
    if (dd) ded_evt <= '{hit: 1'b1, block: blk};
    else sec_evt <= '{hit: 1'b1, block: blk};
    @(posedge aclk);
    sec_evt <= '{hit: 1'b0, block: ~sec_evt.block};
    ded_evt <= '{hit: 1'b0, block: ~ded_evt.block};
  endtask : fault
endmodule : lfdc_frame_src

/* File: tb/tb_link_frame_debug_counters.sv */
/*
  Self-checking bench for the link frame debug counters over AXI4-Lite.
  Assumes the package and the frame source model are compiled first.
*/
`timescale 1ns/100ps
module tb_link_frame_debug_counters
  import lfdc_pkg::*;
;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } lfdc_exp_t;
  localparam logic [10:0] DISC_IDX [LINKS] = '{IDX_UART_DISC, IDX_UPPER_DISC, IDX_LOWER_DISC};
  localparam logic [10:0] VHI_IDX [LINKS] = '{IDX_UART_VHI, IDX_UPPER_VHI, IDX_LOWER_VHI};
  localparam logic [10:0] BAD_IDX [4] = '{11'h788, 11'h792, 11'h79f, 11'h7a2};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [2:0] awprot = '0, arprot = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic aclken = 1'b1;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  lfdc_link_evt_t link_evt [LINKS];
  lfdc_nvm_evt_t sec_evt, ded_evt;
  lfdc_exp_t rq [$];
  logic [1:0] bq [$];
  lfdc_exp_t e;
  logic [1:0] eb;
  int seed = 32'h6f1e181b;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int nd, nv;
  logic [7:0] b0, b1;

  always #12.5 aclk = ~aclk;

  lfdc_frame_src src (.aclk(aclk), .link_evt(link_evt), .sec_evt(sec_evt), .ded_evt(ded_evt));

  lfdc_counters i_dut (
    .aclk(aclk), .aresetn(aresetn), .aclken(aclken), .link_evt(link_evt),
    .single_correct_evt(sec_evt), .double_detect_evt(ded_evt),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic test_done();
    if (rq.size() != 0 || bq.size() != 0) begin
      err_total++;
      $display("[ERR] answers expected %0d seen 0", rq.size() + bq.size());
    end
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // Answers are matched in order against the notes left by the tasks
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      e = (rq.size() != 0) ? rq.pop_front() : '1;
      chk("rdata", e.data, rdata);
      chk("rresp", {30'h0, e.resp}, {30'h0, rresp});
    end
    if (bvalid) begin
      eb = (bq.size() != 0) ? bq.pop_front() : 2'h2;
      chk("bresp", {30'h0, eb}, {30'h0, bresp});
    end
  end

  // Longest path is the saturation burst of about 65.5k cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end

  task automatic rd(input logic [10:0] idx, input logic [7:0] ex, input logic [1:0] er);
    int w;
    w = $random(seed) & 3;
    rq.push_back('{data: {24'h0, ex}, resp: er});
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arprot <= 3'($random(seed));
    arvalid <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    araddr <= ~araddr;
    // Late rready makes the answer stand more than one cycle
    repeat (w) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  task automatic rd16(input int l, input logic [15:0] v);
    rd(VHI_IDX[l], v[15:8], RESP_OKAY);
    rd(VHI_IDX[l] + 11'h1, v[7:0], RESP_OKAY);
  endtask : rd16

  task automatic wr(input logic [10:0] idx, input logic [1:0] er);
    logic a_done;
    logic w_done;
    a_done = 1'b0;
    w_done = 1'b0;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    awprot <= 3'($random(seed));
    wdata <= $random(seed);
    wstrb <= 4'($random(seed));
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      a_done = a_done | awready;
      w_done = w_done | wready;
      if (a_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end while (!(a_done && w_done));
    @(posedge aclk);
    while (!bvalid) @(posedge aclk);
  endtask : wr

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 9; i++) rd(IDX_UART_DISC + 11'(i), 8'h00, RESP_OKAY);
    rd(IDX_SEC_BLK, 8'h00, RESP_OKAY);
    rd(IDX_DED_BLK, 8'h00, RESP_OKAY);
    for (int l = 0; l < LINKS; l++) begin
      nd = 1 + ($random(seed) & 15);
      nv = 1 + ($random(seed) & 31);
      src.burst(l, 1'b1, 1'b0, nd);
      src.burst(l, 1'b0, 1'b1, nv);
      rd(DISC_IDX[l], 8'(nd), RESP_OKAY);
      rd16(l, 16'(nv));
      rd(DISC_IDX[l], 8'h00, RESP_OKAY);
      rd16(l, 16'h0000);
    end
    src.burst(1, 1'b1, 1'b0, 3);
    wr(IDX_UPPER_DISC, RESP_OKAY);
    wr(IDX_UPPER_VLO, RESP_OKAY);
    foreach (BAD_IDX[i]) begin
      wr(BAD_IDX[i], RESP_DECERR);
      rd(BAD_IDX[i], 8'h00, RESP_DECERR);
    end
    rd(IDX_UPPER_DISC, 8'h03, RESP_OKAY);
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    src.fault(1'b0, b0);
    src.fault(1'b1, b1);
    rd(IDX_SEC_BLK, b0, RESP_OKAY);
    rd(IDX_DED_BLK, b1, RESP_OKAY);
    src.fault(1'b0, ~b0);
    rd(IDX_SEC_BLK, ~b0, RESP_OKAY);
    rd(IDX_DED_BLK, b1, RESP_OKAY);
    src.burst(0, 1'b1, 1'b1, 65541);
    rd(IDX_UART_DISC, 8'h05, RESP_OKAY);
    rd16(0, 16'hffff);
    // Frames seen while the clock enable is low must not count
    aclken <= 1'b0;
    src.burst(0, 1'b1, 1'b1, 5);
    aclken <= 1'b1;
    rd(IDX_UART_DISC, 8'h00, RESP_OKAY);
    rd16(0, 16'h0000);
    src.burst(2, 1'b1, 1'b1, 4);
    rd(IDX_LOWER_DISC, 8'h04, RESP_OKAY);
    rd16(2, 16'h0004);
    src.burst(2, 1'b1, 1'b1, 2);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd16(2, 16'h0000);
    rd(IDX_LOWER_DISC, 8'h00, RESP_OKAY);
    rd(IDX_SEC_BLK, 8'h00, RESP_OKAY);
    rd(IDX_DED_BLK, 8'h00, RESP_OKAY);
    @(posedge aclk);
    test_done();
  end
endmodule : tb_link_frame_debug_counters
